// File: design/apb_request_engine.sv
`timescale 1ns/100ps
// ============================================================
// single-transfer bus master toward the device registers
// ============================================================
module apb_request_engine (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic req,
	input wire logic reqWrite,
	input wire logic [two_wire_host_pkg::DEV_AW-1:0] reqAddr,
	input wire logic [31:0] reqWdata,
	output logic done,
	output logic [31:0] rdata,
	output logic devPsel,
	output logic devPenable,
	output logic devPwrite,
	output logic [two_wire_host_pkg::DEV_AW-1:0] devPaddr,
	output logic [31:0] devPwdata,
	input wire logic [31:0] devPrdata,
	input wire logic devPready
);
	import two_wire_host_pkg::*;

	// all engine state
	typedef struct packed {
		bus_phase_e ph;
		logic psel;
		logic penable;
		logic pwrite;
		logic [DEV_AW-1:0] paddr;
		logic [31:0] pwdata;
		logic done;
		logic [31:0] rdata;
	} engine_s;

	engine_s sQ; // registered state
	engine_s sD; // next state

	// ============================================================
	// next state
	// ============================================================
	// done is held back one cycle so the caller can move on; a new request
	// is not taken while done is high, which stops a stale request repeating
	always_comb begin
		sD = sQ;
		sD.done = 1'b0;
		case (sQ.ph)
			PH_IDLE: begin
				// setup cycle: address, direction and data valid
				if (req && !sQ.done) begin
					sD.psel = 1'b1;
					sD.penable = 1'b0;
					sD.pwrite = reqWrite;
					sD.paddr = reqAddr;
					sD.pwdata = reqWdata;
					sD.ph = PH_SETUP;
				end
			end
			PH_SETUP: begin
				sD.penable = 1'b1;
				sD.ph = PH_ACCESS;
			end
			PH_ACCESS: begin
				// request held until the slave answers, however long
				if (devPready) begin
					sD.psel = 1'b0;
					sD.penable = 1'b0;
					sD.done = 1'b1;
					sD.rdata = devPrdata;
					sD.ph = PH_IDLE;
				end
			end
			default: begin
				sD.ph = PH_IDLE;
			end
		endcase
	end

	// ============================================================
	// state register
	// ============================================================
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sQ <= '0;
		end else begin
			sQ <= sD;
		end
	end

	assign done = sQ.done;
	assign rdata = sQ.rdata;
	assign devPsel = sQ.psel;
	assign devPenable = sQ.penable;
	assign devPwrite = sQ.pwrite;
	assign devPaddr = sQ.paddr;
	assign devPwdata = sQ.pwdata;

endmodule

// File: design/two_wire_host.sv
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
// How it works
// - this host never adds a second master
// - pin selects written only while device off
// - pad setup is outside this host
// - device answers last read byte with nack
// - next byte written only after byte sent
// - stop triggered before final byte read
// - next start triggered before final byte read
// - shortcuts all written off
// - wait stopped event, then switch device off
// - device reprogrammed before each command from idle; a chained one only rewrites the slave address
module two_wire_host #(
	parameter int DEPTH = 16,
	parameter logic [31:0] RATE_SLOW_CODE = 32'h0000_0001,
	parameter logic [31:0] RATE_FAST_CODE = 32'h0000_0002,
	parameter logic [31:0] ON_CODE = 32'h0000_0001
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [two_wire_host_pkg::OWN_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic devPsel,
	output logic devPenable,
	output logic devPwrite,
	output logic [two_wire_host_pkg::DEV_AW-1:0] devPaddr,
	output logic [31:0] devPwdata,
	input wire logic [31:0] devPrdata,
	input wire logic devPready
);
	import two_wire_host_pkg::*;

	localparam int IW = $clog2(DEPTH); // data slot index width

	// ============================================================
	// state
	// ============================================================
	typedef struct packed {
		seq_state_e st;
		logic [6:0] slaveAddr; // seven-bit slave address
		logic fast; // fast bus rate selected
		logic [31:0] sclSel; // clock line pin select value
		logic [31:0] sdaSel; // data line pin select value
		logic [IW:0] len; // bytes in the command
		logic [IW:0] idx; // current byte
		logic isRead; // command direction
		logic chain; // end with a repeated start
		logic started; // start task issued for this command
		logic rxPending; // final read byte still unread in the device
		logic stopping; // stop task issued
		logic done; // sticky, command finished
		logic [2:0] errBits; // sticky error causes
		logic [2:0] errSeen; // causes seen this time
		logic [7:0] lastRx; // last byte taken from the device
		logic [2:0] evIdx; // event being cleared during setup
		logic [31:0] rdQ; // read answer for the software bus
		logic errQ; // unmapped access answer
		logic [DEPTH-1:0][7:0] mem; // data slots
	} host_s;

	host_s sQ; // registered state
	host_s sD; // next state

	logic busReq; // request to the engine
	logic busWrite; // its direction
	logic [DEV_AW-1:0] busAddr; // its address
	logic [31:0] busWdata; // its write data
	logic busDone; // engine finished a transfer
	logic [31:0] busRdata; // data the engine read
	logic [IW:0] nextIdx; // index after this byte
	logic isLast; // this byte ends the command
	logic [IW-1:0] slot; // data slot addressed by software
	logic inData; // software address hits a data slot
	logic setup; // software setup cycle
	logic access; // software access cycle

	// ============================================================
	// device bus engine
	// ============================================================
	// sole bus master here
	apb_request_engine engine (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.req(busReq),
		.reqWrite(busWrite),
		.reqAddr(busAddr),
		.reqWdata(busWdata),
		.done(busDone),
		.rdata(busRdata),
		.devPsel(devPsel),
		.devPenable(devPenable),
		.devPwrite(devPwrite),
		.devPaddr(devPaddr),
		.devPwdata(devPwdata),
		.devPrdata(devPrdata),
		.devPready(devPready)
	);

	// event registers cleared during setup
	function automatic logic [DEV_AW-1:0] eventAddr(input logic [2:0] i);
		case (i)
			3'h0: eventAddr = DEV_EV_STOPPED;
			3'h1: eventAddr = DEV_EV_RX;
			3'h2: eventAddr = DEV_EV_TX;
			3'h3: eventAddr = DEV_EV_ERR;
			3'h4: eventAddr = DEV_EV_BOUND;
			default: eventAddr = DEV_EV_SUSP;
		endcase
	endfunction

	assign nextIdx = sQ.idx + 1'b1;
	assign isLast = (nextIdx >= sQ.len);
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign slot = paddr[2 +: IW];
	assign inData = (paddr >= REG_DATA) && (paddr < REG_DATA + 8'(4 * DEPTH));

	// ============================================================
	// transfer asked of the device in each state
	// ============================================================
	always_comb begin
		busReq = 1'b1;
		busWrite = 1'b1;
		busAddr = DEV_ON;
		busWdata = DEV_CLEAR;
		case (sQ.st)
			SQ_CFG_OFF: busWdata = DEV_OFF;
			SQ_CFG_SHORTCUT_CONTROL: begin
				busAddr = DEV_SHORTCUT_CONTROL;
				busWdata = DEV_NO_SHORTCUT_CONTROL;
			end
			SQ_CFG_INTCLR: begin
				busAddr = DEV_INT_CLR;
				busWdata = DEV_ALL_ONES;
			end
			SQ_CFG_EVCLR: busAddr = eventAddr(sQ.evIdx);
			SQ_CFG_ERRCLR: begin
				busAddr = DEV_ERR_CAUSE;
				busWdata = DEV_ALL_ONES;
			end
			SQ_CFG_SCL: begin
				busAddr = DEV_SCL_SEL;
				busWdata = sQ.sclSel;
			end
			SQ_CFG_SDA: begin
				busAddr = DEV_SDA_SEL;
				busWdata = sQ.sdaSel;
			end
			SQ_CFG_RATE: begin
				busAddr = DEV_RATE;
				busWdata = sQ.fast ? RATE_FAST_CODE : RATE_SLOW_CODE;
			end
			SQ_CFG_ON: busWdata = ON_CODE;
			SQ_ADDR_SET: begin
				busAddr = DEV_SLAVE_ADDR;
				busWdata = {25'h0, sQ.slaveAddr};
			end
			SQ_TX_LOAD: begin
				busAddr = DEV_TX_HOLD;
				busWdata = {24'h0, sQ.mem[sQ.idx[IW-1:0]]};
			end
			SQ_START: begin
				busAddr = sQ.isRead ? DEV_START_RX : DEV_START_TX;
				busWdata = DEV_TRIGGER;
			end
			SQ_WAIT_EVT: begin
				busWrite = 1'b0;
				busAddr = sQ.isRead ? DEV_EV_RX : DEV_EV_TX;
			end
			SQ_WAIT_ERR: begin
				busWrite = 1'b0;
				busAddr = DEV_EV_ERR;
			end
			SQ_CLR_EVT: busAddr = sQ.isRead ? DEV_EV_RX : DEV_EV_TX;
			SQ_RX_READ: begin
				busWrite = 1'b0;
				busAddr = DEV_RX_HOLD;
			end
			SQ_ERR_RD: begin
				busWrite = 1'b0;
				busAddr = DEV_ERR_CAUSE;
			end
			// write one to clear what was seen
			SQ_ERR_CLR: begin
				busAddr = DEV_ERR_CAUSE;
				busWdata = {29'h0, sQ.errSeen};
			end
			SQ_ERR_EVCLR: busAddr = DEV_EV_ERR;
			SQ_STOP: begin
				busAddr = DEV_STOP;
				busWdata = DEV_TRIGGER;
			end
			SQ_WAIT_STOP: begin
				busWrite = 1'b0;
				busAddr = DEV_EV_STOPPED;
			end
			SQ_CLR_STOP: busAddr = DEV_EV_STOPPED;
			SQ_DISABLE: busWdata = DEV_OFF;
			// idle and parked ask for nothing
			default: busReq = 1'b0;
		endcase
	end

	// ============================================================
	// sequencer and software registers
	// ============================================================
	always_comb begin
		sD = sQ;
		// sequencer steps on each finished device transfer
		if (busDone) begin
			case (sQ.st)
				SQ_CFG_OFF: sD.st = SQ_CFG_SHORTCUT_CONTROL;
				SQ_CFG_SHORTCUT_CONTROL: sD.st = SQ_CFG_INTCLR;
				SQ_CFG_INTCLR: sD.st = SQ_CFG_EVCLR;
				SQ_CFG_EVCLR: begin
					sD.evIdx = sQ.evIdx + 3'h1;
					if (sQ.evIdx == 3'(NUM_EVENTS - 1)) begin
						sD.st = SQ_CFG_ERRCLR;
					end
				end
				SQ_CFG_ERRCLR: sD.st = SQ_CFG_SCL;
				SQ_CFG_SCL: sD.st = SQ_CFG_SDA;
				SQ_CFG_SDA: sD.st = SQ_CFG_RATE;
				SQ_CFG_RATE: sD.st = SQ_CFG_ON;
				SQ_CFG_ON: sD.st = SQ_ADDR_SET;
				SQ_ADDR_SET: sD.st = sQ.isRead ? SQ_START : SQ_TX_LOAD;
				SQ_TX_LOAD: sD.st = sQ.started ? SQ_WAIT_EVT : SQ_START;
				SQ_START: begin
					sD.started = 1'b1;
					// new start went out before the old byte is read
					sD.st = sQ.rxPending ? SQ_RX_READ : SQ_WAIT_EVT;
				end
				SQ_WAIT_EVT: sD.st = busRdata[0] ? SQ_CLR_EVT : SQ_WAIT_ERR;
				SQ_WAIT_ERR: sD.st = busRdata[0] ? SQ_ERR_RD : SQ_WAIT_EVT;
				SQ_CLR_EVT: begin
					if (isLast) begin
						sD.rxPending = sQ.isRead;
						if (sQ.chain) begin
							sD.st = SQ_PARKED;
						end else begin
							sD.stopping = 1'b1;
							sD.st = SQ_STOP;
						end
					end else if (sQ.isRead) begin
						sD.st = SQ_RX_READ;
					end else begin
						// next byte only after byte sent
						sD.idx = nextIdx;
						sD.st = SQ_TX_LOAD;
					end
				end
				SQ_RX_READ: begin
					sD.lastRx = busRdata[7:0];
					if (sQ.rxPending) begin
						// deferred final byte: slot kept only when stopping
						if (sQ.stopping) begin
							sD.mem[sQ.idx[IW-1:0]] = busRdata[7:0];
						end
						sD.rxPending = 1'b0;
						sD.st = sQ.stopping ? SQ_WAIT_STOP : SQ_WAIT_EVT;
					end else begin
						sD.mem[sQ.idx[IW-1:0]] = busRdata[7:0];
						sD.idx = nextIdx;
						sD.st = SQ_WAIT_EVT;
					end
				end
				SQ_ERR_RD: begin
					sD.errSeen = busRdata[2:0];
					sD.errBits = sQ.errBits | busRdata[2:0];
					sD.st = SQ_ERR_CLR;
				end
				SQ_ERR_CLR: sD.st = SQ_ERR_EVCLR;
				SQ_ERR_EVCLR: begin
					sD.rxPending = 1'b0;
					sD.stopping = 1'b1;
					sD.st = SQ_STOP;
				end
				SQ_STOP: sD.st = sQ.rxPending ? SQ_RX_READ : SQ_WAIT_STOP;
				// off only after the stopped event
				SQ_WAIT_STOP: sD.st = busRdata[0] ? SQ_CLR_STOP : SQ_WAIT_STOP;
				SQ_CLR_STOP: sD.st = SQ_DISABLE;
				SQ_DISABLE: begin
					sD.done = 1'b1;
					sD.st = SQ_IDLE;
				end
				default: sD.st = sQ.st;
			endcase
		end

		// software setup cycle: capture the answer
		if (setup) begin
			sD.errQ = 1'b0;
			sD.rdQ = 32'h0;
			if (inData) begin
				sD.rdQ = {24'h0, sQ.mem[slot]};
			end else begin
				case (paddr)
					REG_CTRL: sD.rdQ = {29'h0, sQ.chain, sQ.isRead, 1'b0};
					REG_CFG: sD.rdQ = {23'h0, sQ.fast, 1'b0, sQ.slaveAddr};
					REG_SCL: sD.rdQ = sQ.sclSel;
					REG_SDA: sD.rdQ = sQ.sdaSel;
					REG_LEN: sD.rdQ = 32'(sQ.len);
					REG_STATUS: begin
						sD.rdQ[ST_BUSY] = (sQ.st != SQ_IDLE) && (sQ.st != SQ_PARKED);
						sD.rdQ[ST_PARKED] = (sQ.st == SQ_PARKED);
						sD.rdQ[ST_DONE] = sQ.done;
						sD.rdQ[ST_PEND] = sQ.rxPending;
						sD.rdQ[ST_ERR +: 3] = sQ.errBits;
						sD.rdQ[ST_IDX +: IW + 1] = sQ.idx;
					end
					REG_LASTRX: sD.rdQ = {24'h0, sQ.lastRx};
					default: sD.errQ = 1'b1;
				endcase
			end
		end

		// software access cycle: writes take effect here
		if (access && pwrite) begin
			if (inData) begin
				sD.mem[slot] = pwdata[7:0];
			end else begin
				case (paddr)
					REG_CTRL: begin
						// go is taken only when idle or parked
						if (pwdata[CTRL_GO] && (sQ.st == SQ_IDLE || sQ.st == SQ_PARKED)) begin
							sD.isRead = pwdata[CTRL_READ];
							sD.chain = pwdata[CTRL_CHAIN];
							sD.idx = '0;
							sD.started = 1'b0;
							sD.stopping = 1'b0;
							sD.done = 1'b0;
							sD.errBits = 3'h0;
							sD.evIdx = 3'h0;
							// a fresh command from idle reprograms the device; one from parked only rewrites the slave address
							sD.st = (sQ.st == SQ_PARKED) ? SQ_ADDR_SET : SQ_CFG_OFF;
						end
					end
					REG_CFG: begin
						sD.slaveAddr = pwdata[6:0];
						sD.fast = pwdata[CFG_FAST];
					end
					REG_SCL: sD.sclSel = pwdata;
					REG_SDA: sD.sdaSel = pwdata;
					REG_LEN: sD.len = pwdata[IW:0];
					default: sD.errQ = sQ.errQ;
				endcase
			end
		end
	end

	// ============================================================
	// state register
	// ============================================================
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sQ <= '0;
			sQ.st <= SQ_IDLE;
			sQ.sclSel <= SEL_RESET;
			sQ.sdaSel <= SEL_RESET;
			sQ.slaveAddr <= ADDR_RESET;
		end else begin
			sQ <= sD;
		end
	end

	// zero wait states: the answer was captured in the setup cycle
	assign pready = access;
	assign prdata = sQ.rdQ;
	assign pslverr = access && sQ.errQ;

endmodule

// File: shared/two_wire_host_pkg.sv
// ============================================================
// constants shared by the host controller and its bus engine
// ============================================================
package two_wire_host_pkg;

	// ============================================================
	// device register map (byte offsets on the device bus)
	// ============================================================
	localparam int DEV_AW = 12;
	localparam logic [11:0] DEV_START_RX = 12'h000;
	localparam logic [11:0] DEV_START_TX = 12'h008;
	localparam logic [11:0] DEV_STOP = 12'h014;
	localparam logic [11:0] DEV_SUSPEND = 12'h01c;
	localparam logic [11:0] DEV_RESUME = 12'h020;
	localparam logic [11:0] DEV_EV_STOPPED = 12'h104;
	localparam logic [11:0] DEV_EV_RX = 12'h108;
	localparam logic [11:0] DEV_EV_TX = 12'h11c;
	localparam logic [11:0] DEV_EV_ERR = 12'h124;
	localparam logic [11:0] DEV_EV_BOUND = 12'h138;
	localparam logic [11:0] DEV_EV_SUSP = 12'h148;
	localparam logic [11:0] DEV_SHORTCUT_CONTROL = 12'h200;
	localparam logic [11:0] DEV_INT_SET = 12'h304;
	localparam logic [11:0] DEV_INT_CLR = 12'h308;
	localparam logic [11:0] DEV_ERR_CAUSE = 12'h4c4;
	localparam logic [11:0] DEV_ON = 12'h500;
	localparam logic [11:0] DEV_SCL_SEL = 12'h508;
	localparam logic [11:0] DEV_SDA_SEL = 12'h50c;
	localparam logic [11:0] DEV_RX_HOLD = 12'h518;
	localparam logic [11:0] DEV_TX_HOLD = 12'h51c;
	localparam logic [11:0] DEV_RATE = 12'h524;
	localparam logic [11:0] DEV_SLAVE_ADDR = 12'h588;

	// values written to the device
	localparam logic [31:0] DEV_TRIGGER = 32'h0000_0001;
	localparam logic [31:0] DEV_CLEAR = 32'h0000_0000;
	localparam logic [31:0] DEV_OFF = 32'h0000_0000;
	localparam logic [31:0] DEV_NO_SHORTCUT_CONTROL = 32'h0000_0000;
	localparam logic [31:0] DEV_ALL_ONES = 32'hffff_ffff;
	localparam int NUM_EVENTS = 6;

	// error cause bit positions
	localparam int ERR_OVERRUN = 0;
	localparam int ERR_ADDR_NACK = 1;
	localparam int ERR_DATA_NACK = 2;

	// ============================================================
	// own register map (byte offsets on the software bus)
	// ============================================================
	localparam int OWN_AW = 8;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CFG = 8'h04;
	localparam logic [7:0] REG_SCL = 8'h08;
	localparam logic [7:0] REG_SDA = 8'h0c;
	localparam logic [7:0] REG_LEN = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] REG_LASTRX = 8'h18;
	localparam logic [7:0] REG_DATA = 8'h40;

	// field positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_READ = 1;
	localparam int CTRL_CHAIN = 2;
	localparam int CFG_FAST = 8;
	localparam int ST_BUSY = 0;
	localparam int ST_PARKED = 1;
	localparam int ST_DONE = 2;
	localparam int ST_PEND = 3;
	localparam int ST_ERR = 4;
	localparam int ST_IDX = 16;

	// values after reset
	localparam logic [31:0] SEL_RESET = 32'h0000_0000;
	localparam logic [6:0] ADDR_RESET = 7'h00;

	// sequencer states
	typedef enum logic [4:0] {
		SQ_IDLE, SQ_CFG_OFF, SQ_CFG_SHORTCUT_CONTROL, SQ_CFG_INTCLR, SQ_CFG_EVCLR,
		SQ_CFG_ERRCLR, SQ_CFG_SCL, SQ_CFG_SDA, SQ_CFG_RATE, SQ_CFG_ON,
		SQ_ADDR_SET, SQ_TX_LOAD, SQ_START, SQ_WAIT_EVT, SQ_WAIT_ERR,
		SQ_CLR_EVT, SQ_RX_READ, SQ_ERR_RD, SQ_ERR_CLR, SQ_ERR_EVCLR,
		SQ_STOP, SQ_WAIT_STOP, SQ_CLR_STOP, SQ_DISABLE, SQ_PARKED
	} seq_state_e;

	// bus engine phases
	typedef enum logic [1:0] {
		PH_IDLE, PH_SETUP, PH_ACCESS
	} bus_phase_e;

endpackage

// File: verification/tb.sv
`timescale 1ns/100ps
// ============================================================
// self-checking bench for the two-wire host
// ============================================================
module tb;
	import two_wire_host_pkg::*;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, nack = 1'b0, busErr, f;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, devPwdata, devPrdata, rd, sel;
	logic pready, pslverr, devPsel, devPenable, devPwrite, devPready;
	logic [11:0] devPaddr;
	logic [6:0] a;
	logic [7:0] want [16];
	integer seed = 32'hdaf0d330;
	int n_errors = 0, comparisons = 0, cycles = 0, len;
	always #25 core_clk = ~core_clk;
	two_wire_host #(.DEPTH(16), .RATE_SLOW_CODE(32'h11), .RATE_FAST_CODE(32'h22), .ON_CODE(32'h5))
		u_dut (.core_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .devPsel, .devPenable, .devPwrite, .devPaddr, .devPwdata, .devPrdata, .devPready);
	two_wire_dev_model u_dev (.core_clk, .devPsel, .devPenable, .devPwrite, .devPaddr, .devPwdata,
		.stall, .nack, .devPrdata, .devPready);
	// random device stalls; a hang ends the run as a failure
	always @(posedge core_clk) begin
		stall <= ($random(seed) & 3) == 0;
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			n_errors++;
			summarize();
		end
	end
	function automatic logic [7:0] rxByte(input int i);
		return 8'h5a ^ i[7:0];
	endfunction
	// ============================================================
	// bus cycle, comparison, run and verdict
	// ============================================================
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		busErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic run(input logic [31:0] ctrl);
		u_dev.sent.delete();
		apb(1'b1, REG_LEN, 32'(len));
		apb(1'b1, REG_CTRL, ctrl);
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
		end while (rd[ST_BUSY] !== 1'b0);
	endtask
	task automatic summarize;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge core_clk);
		sys_rst <= 1'b0;
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, REG_SCL, 32'h0);
		chk(rd, SEL_RESET);
		apb(1'b0, 8'hfc, 32'h0);
		chk({busErr, rd[30:0]}, 32'h8000_0000);
		$display("reset test done");
		// writes: longest, shortest, random lengths
		for (int k = 0; k < 4; k++) begin
			len = (k == 0) ? 16 : (k == 1) ? 1 : 1 + ($random(seed) & 15);
			a = 7'($random(seed));
			f = 1'($random(seed));
			sel = $random(seed);
			for (int i = 0; i < len; i++) begin
				want[i] = 8'($random(seed));
				apb(1'b1, REG_DATA + 8'(4 * i), {24'h0, want[i]});
			end
			apb(1'b1, REG_CFG, {23'h0, f, 1'b0, a});
			apb(1'b1, REG_SCL, sel);
			apb(1'b1, REG_SDA, ~sel);
			run(32'h1);
			chk(rd & 32'h7f, 32'h4);
			chk(32'(u_dev.sent.size()), 32'(len));
			for (int i = 0; i < len; i++) chk({24'h0, u_dev.sent[i]}, {24'h0, want[i]});
			chk(u_dev.regs[DEV_SLAVE_ADDR >> 2], {25'h0, a});
			chk(u_dev.regs[DEV_RATE >> 2], f ? 32'h22 : 32'h11);
			chk(u_dev.regs[DEV_SDA_SEL >> 2], ~sel);
			chk(u_dev.regs[DEV_SCL_SEL >> 2], sel);
			chk(u_dev.regs[DEV_ON >> 2], DEV_OFF);
		end
		$display("write test done");
		for (int k = 0; k < 2; k++) begin
			len = (k == 0) ? 16 : 2 + ($random(seed) & 7);
			run(32'h3);
			chk(rd & 32'h7f, 32'h4);
			chk({24'h0, u_dev.rxCnt}, 32'(len));
			for (int i = 0; i < len; i++) begin
				apb(1'b0, REG_DATA + 8'(4 * i), 32'h0);
				chk(rd & 32'hff, {24'h0, rxByte(i)});
			end
		end
		$display("read test done");
		nack <= 1'b1;
		len = 2;
		run(32'h1);
		chk({29'h0, rd[6:4]}, 32'h2);
		chk(u_dev.regs[DEV_ERR_CAUSE >> 2], 32'h0);
		chk(u_dev.regs[DEV_ON >> 2], DEV_OFF);
		nack <= 1'b0;
		$display("nack test done");
		run(32'h7);
		chk(rd & 32'h3, 32'h2);
		len = 1;
		apb(1'b1, REG_DATA, 32'h3c);
		run(32'h1);
		chk({24'h0, u_dev.sent[0]}, 32'h3c);
		apb(1'b0, REG_LASTRX, 32'h0);
		chk(rd & 32'hff, {24'h0, rxByte(1)});
		$display("chain test done");
		summarize();
	end
endmodule

// File: verification/two_wire_dev_model.sv
`timescale 1ns/100ps
// ============================================================
// register-level model of the two-wire peripheral
// ============================================================
module two_wire_dev_model (
	input wire logic core_clk,
	input wire logic devPsel,
	input wire logic devPenable,
	input wire logic devPwrite,
	input wire logic [two_wire_host_pkg::DEV_AW-1:0] devPaddr,
	input wire logic [31:0] devPwdata,
	input wire logic stall,
	input wire logic nack,
	output logic [31:0] devPrdata,
	output logic devPready
);
	import two_wire_host_pkg::*;
	// register words, bytes seen on the wire, read byte counter
	logic [31:0] regs [0:1023];
	logic [7:0] sent [$];
	logic [7:0] rxCnt = 8'h00;
	logic [7:0] noise = 8'h00;
	logic reading = 1'b0;
	logic txGo = 1'b0;
	logic txFull = 1'b0;
	wire [9:0] w = devPaddr[11:2];
	wire hit = devPsel & devPenable & devPready;
	initial foreach (regs[i]) regs[i] = 32'h0;
	// ready may lag like a stretched clock; an unselected bus shows junk, never old data
	assign devPready = devPsel & devPenable & !stall;
	assign devPrdata = devPsel ? regs[w] : {4{noise}};
	// ============================================================
	// task and register effects at the accepting edge
	// ============================================================
	always @(posedge core_clk) begin
		noise <= noise + 8'h1;
		if (txGo && txFull) begin
			sent.push_back(regs[DEV_TX_HOLD >> 2][7:0]);
			regs[DEV_EV_TX >> 2] <= 32'h1;
			regs[DEV_EV_BOUND >> 2] <= 32'h1;
			txFull <= 1'b0;
		end
		// next byte only after read, so no overrun
		if (hit && !devPwrite && devPaddr == DEV_RX_HOLD && reading) begin
			regs[DEV_RX_HOLD >> 2] <= {24'h0, 8'h5a ^ rxCnt};
			regs[DEV_EV_RX >> 2] <= 32'h1;
			rxCnt <= rxCnt + 8'h1;
		end
		if (hit && devPwrite) begin
			// plain stores, except the error cause, whose ones clear bits; shortcuts and suspend inert
			regs[w] <= devPwdata;
			case (devPaddr)
				DEV_TX_HOLD: txFull <= 1'b1;
				DEV_START_TX, DEV_START_RX: begin
					reading <= devPaddr == DEV_START_RX && !nack;
					txGo <= devPaddr == DEV_START_TX && !nack;
					rxCnt <= 8'h01;
					regs[DEV_EV_ERR >> 2] <= {31'h0, nack};
					regs[DEV_ERR_CAUSE >> 2] <= nack ? 32'h1 << ERR_ADDR_NACK : 32'h0;
					if (devPaddr == DEV_START_RX && !nack) begin
						regs[DEV_RX_HOLD >> 2] <= 32'h5a;
						regs[DEV_EV_RX >> 2] <= 32'h1;
					end
				end
				DEV_STOP: begin
					reading <= 1'b0;
					txGo <= 1'b0;
					regs[DEV_EV_STOPPED >> 2] <= 32'h1;
				end
				DEV_ERR_CAUSE: regs[w] <= regs[w] & ~devPwdata;
				default: ;
			endcase
		end
	end
endmodule

// File: verification/two_wire_host_checker.sv
`timescale 1ns/100ps
// ============================================================
// port-level checks of the host controller
// ============================================================
module two_wire_host_checker (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [two_wire_host_pkg::OWN_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic devPsel,
	input wire logic devPenable,
	input wire logic devPwrite,
	input wire logic [two_wire_host_pkg::DEV_AW-1:0] devPaddr,
	input wire logic [31:0] devPwdata,
	input wire logic [31:0] devPrdata,
	input wire logic devPready
);
	import two_wire_host_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// accepted device transfers
	wire devWr = devPsel & devPenable & devPready & devPwrite;
	wire devRd = devPsel & devPenable & devPready & !devPwrite;
	// device switched on, stop not yet confirmed, byte not yet confirmed sent
	logic onQ, stopWaitQ, txDueQ;
	// ============================================================
	// shadow of device state seen on the bus
	// ============================================================
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			onQ <= 1'b0;
			stopWaitQ <= 1'b0;
			txDueQ <= 1'b0;
		end else begin
			if (devWr && devPaddr == DEV_ON)
				onQ <= devPwdata != DEV_OFF;
			if (devWr && devPaddr == DEV_STOP)
				stopWaitQ <= 1'b1;
			else if (devRd && devPaddr == DEV_EV_STOPPED && devPrdata[0])
				stopWaitQ <= 1'b0;
			if (devWr && devPaddr == DEV_TX_HOLD)
				txDueQ <= 1'b1;
			else if ((devRd && devPaddr == DEV_EV_TX && devPrdata[0]) || (devWr && devPaddr == DEV_STOP))
				txDueQ <= 1'b0;
		end
	end
	sequence devSetup;
		devPsel && !devPenable;
	endsequence
	sequence devAccess;
		devPsel && devPenable;
	endsequence
	sw_ready_a: assert property (psel && penable |-> pready) else $error("no ready in access");
	sw_err_a: assert property (pslverr |-> psel && penable) else $error("stray slave error");
	dev_setup_a: assert property ($rose(devPsel) |-> devSetup ##1 devAccess) else $error("bad setup");
	dev_hold_a: assert property (devAccess ##0 !devPready |=> devAccess ##0
		($stable(devPaddr) && $stable(devPwdata) && $stable(devPwrite))) else $error("request moved");
	dev_release_a: assert property (devAccess ##0 devPready |=> !devPsel && !devPenable)
		else $error("request not released");
	pin_sel_off_a: assert property (devWr &&
		(devPaddr == DEV_SCL_SEL || devPaddr == DEV_SDA_SEL) |-> !onQ) else $error("pin select while on");
	off_after_stop_a: assert property (devWr && devPaddr == DEV_ON |-> !stopWaitQ)
		else $error("disabled before stopped");
	one_short_a: assert property (devWr && devPaddr == DEV_SHORTCUT_CONTROL |->
		devPwdata[1:0] != 2'b11) else $error("two shortcuts");
	tx_after_sent_a: assert property (devWr && devPaddr == DEV_TX_HOLD |-> !txDueQ)
		else $error("byte loaded early");
endmodule
bind two_wire_host two_wire_host_checker u_chk (.core_clk, .sys_rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .devPsel, .devPenable, .devPwrite, .devPaddr,
	.devPwdata, .devPrdata, .devPready);
